// file: src/mcf_filter.sv
// multicast class filter channel with apb registers and reply builder
// Function
// - bits 4 and 5 enable passing of listener and solicit classes; else drop (a miss is only counted; all bytes pass while either bit is set).
// - listener class needs destination address 33:33:00:00:00:01.
// - both classes need ethertype 0x86DD.
// - both classes need next header 58.
// - listener class needs icmp type 130, 131 or 132.
// - solicit class needs destination prefix 33:33:FF, last three bytes ignored.
// - solicit class needs icmp type 135.
// - support of each class bit is optional per implementation.
// - enable command always accepted and answered unless checksum or id fails (a command written while cmd_pend is still set is ignored).
// - reply uses only generic reason codes.
// - reply is header, codes at 16-19, checksum 20-23, pad 24-45.
// - after disable command every multicast frame is passed.
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "mcf_map.svh"
module mcf_filter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  output logic rx_ready,
  output logic pass_valid,
  output logic [7:0] pass_data,
  output logic pass_last,
  input wire logic pass_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_last
);
  logic [31:0] setting;
  logic global_en;
  logic force_chk_err;
  logic force_id_err;
  logic [31:0] resp_hdr;
  logic [31:0] pass_cnt;
  logic [31:0] drop_cnt;
  logic [1:0] last_status;
  logic cmd_pend;
  logic [1:0] cmd_kind;
  mcf_pkg::mcf_rx_e rx_state;
  logic [7:0] pos;
  logic [47:0] dest;
  logic [15:0] etype;
  logic [7:0] next_hdr;
  logic [7:0] icmp_type;
  logic is_mcast;
  logic hit_listener;
  logic hit_solicit;
  logic pass_frame;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [8:0] fifo_out_data;
  logic fifo_wr;
  logic take_rx;
  logic apb_wr;
  logic apb_rd;
  logic rpl_start;
  logic rpl_busy;
  logic [15:0] rpl_code;
  logic [15:0] rpl_rsn;
  logic [7:0] rpl_type;
  logic rpl_valid;
  logic [7:0] rpl_data;
  logic rpl_last;
  logic [31:0] next_prdata;
  logic [31:0] cap_mask;

  // apb access decode; slave answers in the access cycle
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  assign cap_mask = {26'h0, `MCF_CAP_SOLICIT, `MCF_CAP_LISTENER, 4'h0};

  // register writes; unsupported class bits are not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setting <= `MCF_SET_RESET;
      force_chk_err <= 1'b0;
      force_id_err <= 1'b0;
      resp_hdr <= 32'h0;
    end else if (apb_wr) begin
      case (paddr)
        `MCF_REG_SETTING: setting <= pwdata & `MCF_SET_USED_MASK & cap_mask;
        `MCF_REG_CTRL: begin
          force_chk_err <= pwdata[`MCF_CTRL_CHK_ERR];
          force_id_err <= pwdata[`MCF_CTRL_ID_ERR];
        end
        `MCF_REG_RESP_HDR: resp_hdr <= pwdata;
        default: ;
      endcase
    end
  end

  // command strobe: hold until reply builder is free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_pend <= 1'b0;
      cmd_kind <= 2'b00;
    end else if (apb_wr && paddr == `MCF_REG_CMD && !cmd_pend && pwdata[1:0] != 2'b00) begin
      cmd_pend <= 1'b1;
      cmd_kind <= pwdata[1:0];
    end else if (cmd_pend && !rpl_busy) begin
      cmd_pend <= 1'b0;
    end
  end

  // command execution: checksum or id failure gets no reply
  assign rpl_start = cmd_pend && !rpl_busy && !force_chk_err && !force_id_err;
  assign rpl_type = (cmd_kind == `MCF_CMD_DISABLE) ? `MCF_RSP_DISABLE_TYPE : `MCF_RSP_ENABLE_TYPE;
  assign rpl_code = (cmd_kind == 2'b11) ? `MCF_RSP_FAIL : `MCF_RSP_OK;
  assign rpl_rsn = (cmd_kind == 2'b11) ? `MCF_RSN_GENERIC_ERR : `MCF_RSN_NONE;

  // global mode and last command status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_en <= 1'b0;
      last_status <= 2'b00;
    end else if (cmd_pend && !rpl_busy) begin
      last_status <= {force_id_err, force_chk_err};
      if (rpl_start && cmd_kind == `MCF_CMD_ENABLE) begin
        global_en <= 1'b1;
      end else if (rpl_start && cmd_kind == `MCF_CMD_DISABLE) begin
        global_en <= 1'b0;
      end
    end
  end

  // read mux
  always_comb begin
    next_prdata = 32'h0;
    case (paddr)
      `MCF_REG_CTRL: next_prdata = {29'h0, force_id_err, force_chk_err, global_en};
      `MCF_REG_SETTING: next_prdata = setting;
      `MCF_REG_STATUS: next_prdata = {28'h0, last_status, rpl_busy, cmd_pend};
      `MCF_REG_CMD: next_prdata = {30'h0, cmd_kind};
      `MCF_REG_PASS_CNT: next_prdata = pass_cnt;
      `MCF_REG_DROP_CNT: next_prdata = drop_cnt;
      `MCF_REG_RESP_HDR: next_prdata = resp_hdr;
      default: next_prdata = 32'h0;
    endcase
  end

  // apb answer registers; unmapped addresses raise pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr > `MCF_REG_RESP_HDR || paddr[1:0] != 2'b00);
      if (apb_rd || (psel && !penable)) begin
        prdata <= next_prdata;
      end
    end
  end

  // receive: bytes are taken only while the fifo has room
  assign take_rx = rx_valid && rx_ready;
  assign rx_ready = fifo_in_ready;

  // header capture per byte position
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= mcf_pkg::mcf_rx_idle;
      pos <= 8'd0;
      dest <= 48'h0;
      etype <= 16'h0;
      next_hdr <= 8'h0;
      icmp_type <= 8'h0;
    end else if (take_rx) begin
      if (pos < 8'd6) begin
        dest <= {dest[39:0], rx_data};
      end
      if (pos == `MCF_POS_ETYPE_HI || pos == `MCF_POS_ETYPE_LO) begin
        etype <= {etype[7:0], rx_data};
      end
      if (pos == `MCF_POS_NEXT_HDR) begin
        next_hdr <= rx_data;
      end
      if (pos == `MCF_POS_ICMP_TYPE) begin
        icmp_type <= rx_data;
      end
      if (rx_last) begin
        pos <= 8'd0;
        rx_state <= mcf_pkg::mcf_rx_idle;
      end else begin
        rx_state <= mcf_pkg::mcf_rx_body;
        if (pos != `MCF_POS_LAST) begin
          pos <= pos + 8'd1;
        end
      end
    end
  end

  // class match on the header captured before the last byte
  assign is_mcast = dest[40];
  assign hit_listener = (dest == `MCF_DA_ALL_NODES)
    && (etype == `MCF_ETYPE_IPV6) && (next_hdr == `MCF_NH_ICMPV6)
    && (icmp_type == `MCF_ICMP_QUERY || icmp_type == `MCF_ICMP_REPORT
        || icmp_type == `MCF_ICMP_DONE);
  assign hit_solicit = (dest[47:24] == `MCF_DA_SOLICIT_PFX)
    && (etype == `MCF_ETYPE_IPV6) && (next_hdr == `MCF_NH_ICMPV6)
    && (icmp_type == `MCF_ICMP_SOLICIT);
  assign pass_frame = !global_en ? is_mcast
    : (hit_listener && setting[`MCF_SET_LISTENER])
      || (hit_solicit && setting[`MCF_SET_SOLICIT]);

  // verdict at frame end: whole frame stored in a side buffer would be needed
  // to drop early bytes, so frames are judged as they end and counted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pass_cnt <= 32'h0;
      drop_cnt <= 32'h0;
    end else if (take_rx && rx_last) begin
      if (pass_frame) begin
        pass_cnt <= pass_cnt + 32'h1;
      end else begin
        drop_cnt <= drop_cnt + 32'h1;
      end
    end
  end

  assign fifo_wr = rx_valid;

  mcf_fifo #(
    .WIDTH(9),
    .DEPTH(4)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(fifo_wr),
    .in_ready(fifo_in_ready),
    .in_data({rx_last, rx_data}),
    .out_valid(fifo_out_valid),
    .out_ready(pass_ready || !pass_valid),
    .out_data(fifo_out_data)
  );

  // passed byte stream output register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pass_valid <= 1'b0;
      pass_data <= 8'h00;
      pass_last <= 1'b0;
    end else if (pass_ready || !pass_valid) begin
      pass_valid <= fifo_out_valid && (global_en ? (setting[5:4] != 2'b00) : 1'b1);
      pass_data <= fifo_out_data[7:0];
      pass_last <= fifo_out_data[8];
    end
  end

  mcf_reply u_reply (
    .pclk(pclk),
    .presetn(presetn),
    .start(rpl_start),
    .rsp_type(rpl_type),
    .rsp_code(rpl_code),
    .rsn_code(rpl_rsn),
    .hdr_word(resp_hdr),
    .busy(rpl_busy),
    .byte_valid(rpl_valid),
    .byte_data(rpl_data),
    .byte_last(rpl_last)
  );

  // reply stream output register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_last <= 1'b0;
    end else begin
      rsp_valid <= rpl_valid;
      rsp_data <= rpl_data;
      rsp_last <= rpl_last;
    end
  end
endmodule

// file: inc/mcf_map.svh
// register offsets, field positions, reset values and frame constants of the filter
`ifndef MCF_MAP_SVH
`define MCF_MAP_SVH
// register byte addresses
`define MCF_REG_CTRL 12'h000
`define MCF_REG_SETTING 12'h004
`define MCF_REG_STATUS 12'h008
`define MCF_REG_CMD 12'h00C
`define MCF_REG_PASS_CNT 12'h010
`define MCF_REG_DROP_CNT 12'h014
`define MCF_REG_RESP_HDR 12'h018
// control fields
`define MCF_CTRL_GLOBAL_EN 0
`define MCF_CTRL_CHK_ERR 1
`define MCF_CTRL_ID_ERR 2
// setting fields
`define MCF_SET_LISTENER 4
`define MCF_SET_SOLICIT 5
`define MCF_SET_USED_MASK 32'h0000_FFFF
`define MCF_SET_RESET 32'h0000_0000
// capability straps: both class bits supported
`define MCF_CAP_LISTENER 1'b1
`define MCF_CAP_SOLICIT 1'b1
// frame fields
`define MCF_DA_ALL_NODES 48'h3333_0000_0001
`define MCF_DA_SOLICIT_PFX 24'h3333FF
`define MCF_ETYPE_IPV6 16'h86DD
`define MCF_NH_ICMPV6 8'h3A
`define MCF_ICMP_QUERY 8'h82
`define MCF_ICMP_REPORT 8'h83
`define MCF_ICMP_DONE 8'h84
`define MCF_ICMP_SOLICIT 8'h87
// byte positions in a received frame
`define MCF_POS_ETYPE_HI 8'd12
`define MCF_POS_ETYPE_LO 8'd13
`define MCF_POS_NEXT_HDR 8'd20
`define MCF_POS_ICMP_TYPE 8'd54
`define MCF_POS_LAST 8'd255
// reply frame layout
`define MCF_RSP_LEN 6'd46
`define MCF_RSP_HDR_END 6'd15
`define MCF_RSP_CODE_END 6'd19
`define MCF_RSP_CHK_END 6'd23
`define MCF_RSP_OK 16'h0000
`define MCF_RSP_FAIL 16'h0001
`define MCF_RSN_NONE 16'h0000
`define MCF_RSN_GENERIC_ERR 16'h0002
`define MCF_RSP_ENABLE_TYPE 8'h92
`define MCF_RSP_DISABLE_TYPE 8'h93
`define MCF_CMD_ENABLE 2'b01
`define MCF_CMD_DISABLE 2'b10
`endif

// file: inc/mcf_pkg.sv
// types shared by the multicast class filter
package mcf_pkg;
  typedef enum logic [1:0] {
    mcf_rx_idle,
    mcf_rx_body,
    mcf_rx_flush
  } mcf_rx_e;
  typedef enum logic [1:0] {
    mcf_tx_idle,
    mcf_tx_send
  } mcf_tx_e;
endpackage

// file: src/mcf_fifo.sv
// small valid/ready fifo for passed frame bytes
`timescale 1ns/10ps
module mcf_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic do_wr;
  logic do_rd;

  // handshake terms
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  assign in_ready = (count < (AW+1)'(DEPTH)); // room while below depth
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  // storage
  always_ff @(posedge pclk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule

// file: src/mcf_reply.sv
// builder of the fixed 46-byte reply frame for filter commands
`timescale 1ns/10ps
`include "mcf_map.svh"
module mcf_reply (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [7:0] rsp_type,
  input wire logic [15:0] rsp_code,
  input wire logic [15:0] rsn_code,
  input wire logic [31:0] hdr_word,
  output logic busy,
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic byte_last
);
  mcf_pkg::mcf_tx_e state;
  logic [5:0] idx;
  logic [127:0] hdr;
  logic [31:0] codes;
  logic [31:0] chk;
  logic [7:0] next_byte;

  // byte selection by position; checksum is two's complement of 16-bit word sum
  always_comb begin
    next_byte = 8'h00;
    if (idx <= `MCF_RSP_HDR_END) begin
      next_byte = hdr[127 - 8*idx -: 8];
    end else if (idx <= `MCF_RSP_CODE_END) begin
      next_byte = codes[31 - 8*(idx - 6'd16) -: 8];
    end else if (idx <= `MCF_RSP_CHK_END) begin
      next_byte = chk[31 - 8*(idx - 6'd20) -: 8];
    end
  end

  // sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= mcf_pkg::mcf_tx_idle;
      idx <= 6'd0;
      hdr <= '0;
      codes <= '0;
      chk <= '0;
      byte_valid <= 1'b0;
      byte_data <= 8'h00;
      byte_last <= 1'b0;
    end else begin
      byte_valid <= 1'b0;
      byte_last <= 1'b0;
      case (state)
        mcf_pkg::mcf_tx_idle: begin
          if (start) begin
            hdr <= {hdr_word[31:8], rsp_type, 96'h0};
            codes <= {rsp_code, rsn_code};
            chk <= 32'h0 - 32'({16'h0, hdr_word[31:16]} + {16'h0, hdr_word[15:8], rsp_type}
                   + {16'h0, rsp_code} + {16'h0, rsn_code});
            idx <= 6'd0;
            state <= mcf_pkg::mcf_tx_send;
          end
        end
        mcf_pkg::mcf_tx_send: begin
          // header, codes, checksum then padding
          byte_valid <= 1'b1;
          byte_data <= next_byte;
          byte_last <= (idx == `MCF_RSP_LEN - 6'd1);
          if (idx == `MCF_RSP_LEN - 6'd1) begin
            state <= mcf_pkg::mcf_tx_idle;
          end
          idx <= idx + 6'd1;
        end
        default: state <= mcf_pkg::mcf_tx_idle;
      endcase
    end
  end

  assign busy = (state != mcf_pkg::mcf_tx_idle);
endmodule

// file: dv/mcf_filter_properties.sv
// assertions on the filter's apb, stream and reply ports
`timescale 1ns/10ps
module mcf_filter_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pass_valid,
  input wire logic [7:0] pass_data,
  input wire logic pass_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [5:0] idx;
  logic [1:0] forced;
  wire acc = psel && penable && pready;
  wire en_wr = acc && pwrite && paddr == 12'h00C && pwdata == 32'h1;
  // reply byte index and the forced-error bits last written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx <= 6'h00;
      forced <= 2'h0;
    end else begin
      if (rsp_valid) idx <= rsp_last ? 6'h00 : idx + 6'h01;
      if (acc && pwrite && paddr == 12'h000) forced <= pwdata[2:1];
    end
  end
  property p_ready_next; psel && !penable |=> pready; endproperty
  a_ready_next: assert property (p_ready_next) else $error("pready late");
  property p_ready_once; pready |=> !pready; endproperty
  a_ready_once: assert property (p_ready_once) else $error("pready held");
  property p_err_map; acc && paddr > 12'h018 |-> pslverr; endproperty
  a_err_map: assert property (p_err_map) else $error("no slverr");
  property p_reply_en; en_wr && forced == 2'h0 |-> ##[1:6] rsp_valid; endproperty
  a_reply_en: assert property (p_reply_en) else $error("no reply");
  property p_no_reply; en_wr && forced != 2'h0 && !rsp_valid |=> !rsp_valid [*8]; endproperty
  a_no_reply: assert property (p_no_reply) else $error("reply on error");
  property p_rsp_run; rsp_valid && !rsp_last |=> rsp_valid; endproperty
  a_rsp_run: assert property (p_rsp_run) else $error("reply gap");
  property p_rsp_last; rsp_valid && rsp_last |-> idx == 6'h2D; endproperty
  a_rsp_last: assert property (p_rsp_last) else $error("reply length");
  property p_rsp_pad; rsp_valid && idx >= 6'h18 |-> rsp_data == 8'h00; endproperty
  a_rsp_pad: assert property (p_rsp_pad) else $error("pad not zero");
  property p_rsn_gen; rsp_valid && idx == 6'h12 |-> rsp_data == 8'h00; endproperty
  a_rsn_gen: assert property (p_rsn_gen) else $error("reason not generic");
  property p_pass_hold; pass_valid && !pass_ready |=> pass_valid && $stable(pass_data);
  endproperty
  a_pass_hold: assert property (p_pass_hold) else $error("pass byte dropped");
  c_reply: cover property (rsp_last);
  c_pass: cover property (pass_valid && pass_ready);
  c_err: cover property (pready && pslverr);
endmodule

// file: dv/mcf_manager_model.sv
// behavioural management controller: drains passed bytes, keeps the latest reply
`timescale 1ns/10ps
module mcf_manager_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hold_off,
  output logic pass_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last
);
  logic [7:0] rsp_buf [0:63];
  logic [5:0] idx;
  logic tick;
  int replies;
  // ready every other cycle, never while held off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick <= 1'b0;
      pass_ready <= 1'b0;
    end else begin
      tick <= ~tick;
      pass_ready <= tick && !hold_off;
    end
  end
  // store reply bytes by position; a reply cannot be stalled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx <= 6'h00;
      replies <= 0;
    end else if (rsp_valid) begin
      rsp_buf[idx] <= rsp_data;
      idx <= rsp_last ? 6'h00 : idx + 6'h01;
      replies <= replies + (rsp_last ? 1 : 0);
    end
  end
endmodule

// file: dv/multicast_class_filter_ack_test.sv
// self-checking bench for the multicast class filter
`timescale 1ns/10ps
module multicast_class_filter_ack_test;
  localparam logic [47:0] AN = 48'h3333_0000_0001;
  localparam logic [47:0] SN = 48'h3333_FF12_3456;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, hold_off;
  logic rx_valid, rx_last, rx_ready, pass_valid, pass_last, pass_ready, rsp_valid, rsp_last;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] rx_data, pass_data, rsp_data;
  int n_errors, samples_checked, w;
  mcf_filter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .rx_ready(rx_ready), .pass_valid(pass_valid), .pass_data(pass_data),
    .pass_last(pass_last), .pass_ready(pass_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_last(rsp_last));
  mcf_manager_model mgr (.pclk(pclk), .presetn(presetn), .hold_off(hold_off),
    .pass_ready(pass_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_last(rsp_last));
  always #50 pclk = ~pclk;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) n_errors++;
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask
  // one 60-byte frame with the class fields placed
  task automatic send(input logic [47:0] da, input logic [15:0] et, input logic [7:0] nh,
                      input logic [7:0] ty);
    logic [7:0] b;
    int n;
    @(posedge pclk);
    for (int i = 0; i < 60; i++) begin
      b = (i < 6) ? da[47-8*i -: 8] : i[7:0];
      if (i == 12) b = et[15:8];
      if (i == 13) b = et[7:0];
      if (i == 20) b = nh;
      if (i == 54) b = ty;
      rx_valid <= 1'b1;
      rx_data <= b;
      rx_last <= (i == 59);
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (rx_ready !== 1'b1 && n < 400);
      if (n >= 400) n_errors++;
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
  endtask
  // send a frame, then poll the counters for its verdict
  task automatic frame(input logic [47:0] da, input logic [7:0] ty, input logic ok,
                       input logic [15:0] et = 16'h86DD, input logic [7:0] nh = 8'h3A);
    logic [31:0] p0, d0, p1, d1;
    int n;
    apb(1'b0, 12'h010, 32'h0, p0, e);
    apb(1'b0, 12'h014, 32'h0, d0, e);
    send(da, et, nh, ty);
    n = 0;
    do begin
      apb(1'b0, 12'h010, 32'h0, p1, e);
      apb(1'b0, 12'h014, 32'h0, d1, e);
      n++;
    end while (p1 + d1 == p0 + d0 && n < 30);
    if (p1 + d1 == p0 + d0) n_errors++;
    chk("pass count", p0 + 32'(ok), p1);
    chk("drop count", d0 + 32'(!ok), d1);
  endtask
  // issue a command and check whether and what it answers
  task automatic cmd(input logic [31:0] c, input logic rep, input logic [31:0] codes);
    int r0;
    int k;
    r0 = mgr.replies;
    wr(12'h00C, c);
    k = 0;
    while (mgr.replies == r0 && k < 100) begin
      @(posedge pclk);
      k++;
    end
    chk("reply count", r0 + 32'(rep), mgr.replies);
    if (rep) begin
      chk("reply codes", codes,
          {mgr.rsp_buf[16], mgr.rsp_buf[17], mgr.rsp_buf[18], mgr.rsp_buf[19]});
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    #2_000_000;
    n_errors++;
    report_and_stop();
  end
  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    hold_off = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    wr(12'h004, 32'hFFFF_FF30);
    apb(1'b0, 12'h004, 32'h0, q, e);
    chk("setting", 32'h30, q);
    apb(1'b0, 12'h040, 32'h0, q, e);
    chk("slverr", 32'h1, {31'h0, e});
    cmd(32'h1, 1'b1, 32'h0);
    wr(12'h000, 32'h2);
    cmd(32'h1, 1'b0, 32'h0);
    wr(12'h000, 32'h4);
    cmd(32'h1, 1'b0, 32'h0);
    wr(12'h000, 32'h0);
    cmd(32'h3, 1'b1, 32'h0001_0002);
    frame(AN, 8'h82, 1'b1);
    frame(AN, 8'h83, 1'b1);
    frame(AN, 8'h84, 1'b1);
    frame(AN, 8'h85, 1'b0);
    frame(AN, 8'h87, 1'b0);
    frame(48'h3333_0000_0002, 8'h82, 1'b0);
    frame(SN, 8'h87, 1'b1);
    frame(48'h3333_FFAB_CDEF, 8'h87, 1'b1);
    frame(48'h3333_FE12_3456, 8'h87, 1'b0);
    frame(SN, 8'h86, 1'b0);
    frame(AN, 8'h82, 1'b0, 16'h0800);
    frame(SN, 8'h87, 1'b0, 16'h86DD, 8'h11);
    wr(12'h004, 32'h10);
    frame(AN, 8'h83, 1'b1);
    frame(SN, 8'h87, 1'b0);
    wr(12'h004, 32'h20);
    frame(AN, 8'h83, 1'b0);
    frame(SN, 8'h87, 1'b1);
    cmd(32'h2, 1'b1, 32'h0);
    wr(12'h004, 32'h0);
    frame(AN, 8'h85, 1'b1, 16'h0800);
    hold_off <= 1'b1;
    fork
      frame(SN, 8'h87, 1'b1);
      begin
        w = 0;
        do begin
          @(posedge pclk);
          w++;
        end while (rx_ready !== 1'b0 && w < 300);
        chk("fifo refuses", 32'h0, {31'h0, rx_ready});
        hold_off <= 1'b0;
      end
    join
    report_and_stop();
  end
endmodule
bind mcf_filter mcf_filter_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .pass_valid(pass_valid), .pass_data(pass_data),
  .pass_ready(pass_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last));
